/* File: rtl/fac_top.v */
// frame alignment control registers, trigger logic and alignment strobes
//
// How it works
// - secondary mode: auto, one-shot, always, never
// - tertiary mode decodes identically, resets never
// - audio mode same codes, source bit picks trigger
// - source 0: init pin rising edge triggers
// - source 1: writing audio trigger bit triggers
// - trigger acts only with written mode not 3
// - written mode 3 ignores trigger bit
// - audio mode 3 blocks init pin
// - strobe: frame plus one to two lines
// - strobe rises immediately, no line wait
// - trigger bits self-clear, read zero
// - horizontal-only forces primary mode never
`timescale 1ns/1ps
`include "fac_map.vh"
module fac_top
#(
	parameter LINE_W = 13
)
(
	// clock and synchronous reset
	input wire mclk,
	input wire reset,
	// register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// video timing
	input wire hsync_pulse,
	input wire [LINE_W-1:0] lines_per_frame,
	// external initialise pin
	input wire init_pin,
	// primary frame pulse control
	input wire h_only,
	input wire [1:0] primary_mode_raw,
	output reg [1:0] primary_align_mode_eff,
	// mode fields
	output wire [1:0] secondary_frame_align_mode,
	output wire [1:0] tertiary_frame_align_mode,
	output wire [1:0] audio_sync_align_mode,
	output wire audio_trigger_source_sel,
	// decoded modes, one bit per channel: secondary, tertiary, audio
	output wire [2:0] auto_align,
	output wire [2:0] always_align,
	output wire [2:0] oneshot_align,
	// alignment strobes
	output wire secondary_align_strobe,
	output wire tertiary_align_strobe,
	output wire audio_align_strobe
);
	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	// secondary mode field
	reg [1:0] sec_mode_q;
	// tertiary mode field
	reg [1:0] ter_mode_q;
	// audio mode field
	reg [1:0] aud_mode_q;
	// audio trigger source select
	reg aud_src_q;
	// decoded mode flags per channel
	reg [2:0] auto_q;
	reg [2:0] always_q;
	reg [2:0] oneshot_q;

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	// address hits
	wire wr_sec;
	wire wr_ter;
	wire wr_aud;
	// mode and trigger as written this cycle
	wire [1:0] wr_mode;
	wire wr_trig;
	wire wr_src;
	// trigger pulses
	wire fire_sec;
	wire fire_ter;
	wire fire_aud_reg;
	wire fire_aud_pin;
	wire fire_aud;
	// synchronised init pin rising edge
	wire init_rise;
	// mode vector for the decode loop
	wire [5:0] mode_vec;

	assign wr_sec = reg_wr & (reg_addr == `FAC_SECONDARY_CTRL_ADDR);
	assign wr_ter = reg_wr & (reg_addr == `FAC_TERTIARY_CTRL_ADDR);
	assign wr_aud = reg_wr & (reg_addr == `FAC_AUDIO_CTRL_ADDR);
	assign wr_mode = reg_wdata[`FAC_MODE_HI:`FAC_MODE_LO];
	assign wr_trig = reg_wdata[`FAC_TRIGGER_BIT];
	assign wr_src = reg_wdata[`FAC_SRC_SEL_BIT];

	// ----------------------------------------------------------------
	// trigger qualification
	// ----------------------------------------------------------------
	// written mode other than never; pin trigger uses stored audio mode
	assign fire_sec = wr_sec & wr_trig & (wr_mode != `FAC_MODE_NEVER);
	assign fire_ter = wr_ter & wr_trig & (wr_mode != `FAC_MODE_NEVER);
	assign fire_aud_reg = wr_aud & wr_trig & wr_src & (wr_mode != `FAC_MODE_NEVER);
	assign fire_aud_pin = init_rise & ~aud_src_q & (aud_mode_q != `FAC_MODE_NEVER);
	// either audio source
	assign fire_aud = fire_aud_reg | fire_aud_pin;

	// ----------------------------------------------------------------
	// control register writes
	// ----------------------------------------------------------------
	// secondary mode field, resets never
	always @(posedge mclk)
	begin
		if (reset)
		begin
			sec_mode_q <= `FAC_MODE_RESET;
		end
		else if (wr_sec)
		begin
			sec_mode_q <= wr_mode;
		end
	end

	always @(posedge mclk)
	begin
		if (reset)
		begin
			ter_mode_q <= `FAC_MODE_RESET;
		end
		else if (wr_ter)
		begin
			ter_mode_q <= wr_mode;
		end
	end

	always @(posedge mclk)
	begin
		if (reset)
		begin
			aud_mode_q <= `FAC_MODE_RESET;
			aud_src_q <= `FAC_SRC_SEL_RESET;
		end
		else if (wr_aud)
		begin
			aud_mode_q <= wr_mode;
			aud_src_q <= wr_src;
		end
	end

	// ----------------------------------------------------------------
	// mode decode per channel
	// ----------------------------------------------------------------
	// pack fields so one loop serves all channels
	assign mode_vec = {aud_mode_q, ter_mode_q, sec_mode_q};

	genvar ch;
	generate
		for (ch = 0; ch < 3; ch = ch + 1)
		begin : g_decode
			always @(posedge mclk)
			begin
				if (reset)
				begin
					auto_q[ch] <= 1'b0;
					always_q[ch] <= 1'b0;
					oneshot_q[ch] <= 1'b0;
				end
				else
				begin
					auto_q[ch] <= (mode_vec[2*ch+1:2*ch] == `FAC_MODE_AUTO);
					always_q[ch] <= (mode_vec[2*ch+1:2*ch] == `FAC_MODE_ALWAYS);
					oneshot_q[ch] <= (mode_vec[2*ch+1:2*ch] == `FAC_MODE_ONESHOT);
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// primary frame pulse mode override
	// ----------------------------------------------------------------
	// horizontal-only forces never
	always @(posedge mclk)
	begin
		if (reset)
		begin
			primary_align_mode_eff <= `FAC_MODE_RESET;
		end
		else if (h_only)
		begin
			primary_align_mode_eff <= `FAC_MODE_NEVER;
		end
		else
		begin
			primary_align_mode_eff <= primary_mode_raw;
		end
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	// trigger bits always read zero
	always @(posedge mclk)
	begin
		if (reset)
		begin
			reg_rdata <= `FAC_RDATA_RESET;
		end
		else if (reg_rd)
		begin
			case (reg_addr)
				`FAC_SECONDARY_CTRL_ADDR:
				begin
					reg_rdata <= {2'h0, sec_mode_q, 4'h0};
				end
				`FAC_TERTIARY_CTRL_ADDR:
				begin
					reg_rdata <= {2'h0, ter_mode_q, 4'h0};
				end
				`FAC_AUDIO_CTRL_ADDR:
				begin
					reg_rdata <= {2'h0, aud_mode_q, aud_src_q, 3'h0};
				end
				default:
				begin
					// unmapped offsets read zero
					reg_rdata <= 8'h00;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// init pin synchroniser
	// ----------------------------------------------------------------
	// synchronised edge detect
	fac_pin_sync u_pin_sync
	(
		.mclk(mclk),
		.reset(reset),
		.pin_in(init_pin),
		.rise_q(init_rise)
	);

	// ----------------------------------------------------------------
	// alignment strobe timers
	// ----------------------------------------------------------------
	// secondary strobe width
	fac_strobe #(.LINE_W(LINE_W)) u_sec_strobe
	(
		.mclk(mclk),
		.reset(reset),
		.fire(fire_sec),
		.hsync_pulse(hsync_pulse),
		.lines_per_frame(lines_per_frame),
		.strobe_q(secondary_align_strobe)
	);

	fac_strobe #(.LINE_W(LINE_W)) u_ter_strobe
	(
		.mclk(mclk),
		.reset(reset),
		.fire(fire_ter),
		.hsync_pulse(hsync_pulse),
		.lines_per_frame(lines_per_frame),
		.strobe_q(tertiary_align_strobe)
	);

	fac_strobe #(.LINE_W(LINE_W)) u_aud_strobe
	(
		.mclk(mclk),
		.reset(reset),
		.fire(fire_aud),
		.hsync_pulse(hsync_pulse),
		.lines_per_frame(lines_per_frame),
		.strobe_q(audio_align_strobe)
	);

	// ----------------------------------------------------------------
	// output wiring, all from flops
	// ----------------------------------------------------------------
	assign secondary_frame_align_mode = sec_mode_q;
	assign tertiary_frame_align_mode = ter_mode_q;
	assign audio_sync_align_mode = aud_mode_q;
	assign audio_trigger_source_sel = aud_src_q;
	assign auto_align = auto_q;
	assign always_align = always_q;
	assign oneshot_align = oneshot_q;
endmodule

/* File: rtl/fac_map.vh */
// register offsets, field positions and reset values for frame alignment control
`ifndef FAC_MAP_VH
`define FAC_MAP_VH
// register offsets
`define FAC_SECONDARY_CTRL_ADDR 8'h12
`define FAC_TERTIARY_CTRL_ADDR 8'h13
`define FAC_AUDIO_CTRL_ADDR 8'h14
// field positions
`define FAC_MODE_HI 5
`define FAC_MODE_LO 4
`define FAC_SRC_SEL_BIT 3
`define FAC_TRIGGER_BIT 0
// alignment mode codes
`define FAC_MODE_AUTO 2'h0
`define FAC_MODE_ONESHOT 2'h1
`define FAC_MODE_ALWAYS 2'h2
`define FAC_MODE_NEVER 2'h3
// reset values
`define FAC_MODE_RESET 2'h3
`define FAC_SRC_SEL_RESET 1'h0
`define FAC_RDATA_RESET 8'h00
`endif

/* File: rtl/fac_pin_sync.v */
// two-stage synchroniser and rising edge detector for the initialise pin
`timescale 1ns/1ps
module fac_pin_sync
(
	input wire mclk,
	input wire reset,
	input wire pin_in,
	output reg rise_q
);
	// first and second synchroniser stages, previous sample
	reg meta_q;
	reg sync_q;
	reg prev_q;

	// ----------------------------------------------------------------
	// synchroniser and edge detector
	// ----------------------------------------------------------------
	// two flops, then compare
	always @(posedge mclk)
	begin
		if (reset)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
			rise_q <= 1'b0;
		end
		else
		begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
			rise_q <= sync_q & ~prev_q;
		end
	end
endmodule

/* File: rtl/fac_strobe.v */
// alignment strobe timer counted in line periods
`timescale 1ns/1ps
module fac_strobe
#(
	parameter LINE_W = 13
)
(
	input wire mclk,
	input wire reset,
	input wire fire,
	input wire hsync_pulse,
	input wire [LINE_W-1:0] lines_per_frame,
	output reg strobe_q
);
	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_WAIT_LINE = 2'h1;
	localparam [1:0] ST_FRAME = 2'h2;

	// state and remaining line count
	reg [1:0] state_q;
	reg [LINE_W-1:0] lines_q;

	// ----------------------------------------------------------------
	// strobe sequencer
	// ----------------------------------------------------------------
	// load, count frame, end on line
	always @(posedge mclk)
	begin
		if (reset)
		begin
			state_q <= ST_IDLE;
			lines_q <= {LINE_W{1'b0}};
			strobe_q <= 1'b0;
		end
		else if (fire)
		begin
			// raise at once, restart if busy
			state_q <= ST_WAIT_LINE;
			lines_q <= lines_per_frame;
			strobe_q <= 1'b1;
		end
		else
		begin
			case (state_q)
				ST_WAIT_LINE:
				begin
					// first line sync opens the frame count
					if (hsync_pulse)
					begin
						state_q <= ST_FRAME;
						lines_q <= lines_per_frame;
					end
				end
				ST_FRAME:
				begin
					// frame plus one to two lines
					if (hsync_pulse)
					begin
						if (lines_q == {LINE_W{1'b0}})
						begin
							state_q <= ST_IDLE;
							strobe_q <= 1'b0;
						end
						else
						begin
							lines_q <= lines_q - {{(LINE_W-1){1'b0}}, 1'b1};
						end
					end
				end
				ST_IDLE:
				begin
					strobe_q <= 1'b0;
				end
				default:
				begin
					state_q <= ST_IDLE;
					strobe_q <= 1'b0;
				end
			endcase
		end
	end
endmodule

/* File: dv/fac_video_model.sv */
// line sync source standing in for the video timing side
`timescale 1ns/1ps
module fac_video_model
#(
	parameter LINE_CYC = 8
)
(
	input wire logic mclk,
	input wire logic reset,
	output logic hsync_pulse
);
	// ----------------------------------------
	// line timer
	// ----------------------------------------
	logic [7:0] cnt_q; // cycles into the line
	// one-cycle sync pulse at the end of each line
	always @(posedge mclk)
	begin
		if (reset)
		begin
			cnt_q <= 8'h00;
			hsync_pulse <= 1'b0;
		end
		else
		begin
			cnt_q <= (cnt_q == LINE_CYC - 1) ? 8'h00 : cnt_q + 8'h01;
			hsync_pulse <= (cnt_q == LINE_CYC - 1);
		end
	end
endmodule

/* File: dv/fac_top_props.sv */
// concurrent checks on the frame alignment control ports
`timescale 1ns/1ps
module fac_top_props
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic h_only,
	input wire logic [1:0] primary_align_mode_eff,
	input wire logic [1:0] secondary_frame_align_mode,
	input wire logic [1:0] tertiary_frame_align_mode,
	input wire logic [1:0] audio_sync_align_mode,
	input wire logic audio_trigger_source_sel,
	input wire logic [2:0] oneshot_align,
	input wire logic secondary_align_strobe,
	input wire logic tertiary_align_strobe,
	input wire logic audio_align_strobe
);
	// ----------------------------------------
	// clocking
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// write data of the previous cycle, for the stored-field check
	logic [7:0] wdata_q;
	always @(posedge mclk)
	begin
		wdata_q <= reg_wdata;
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	AST_SEC_FIRE: assert property (reg_wr && reg_addr == 8'h12 && reg_wdata[0]
		&& reg_wdata[5:4] != 2'h3 |=> secondary_align_strobe)
		else $error("secondary strobe did not rise");
	AST_TER_FIRE: assert property (reg_wr && reg_addr == 8'h13 && reg_wdata[0]
		&& reg_wdata[5:4] != 2'h3 |=> tertiary_align_strobe)
		else $error("tertiary strobe did not rise");
	AST_AUD_FIRE: assert property (reg_wr && reg_addr == 8'h14 && reg_wdata[0]
		&& reg_wdata[3] && reg_wdata[5:4] != 2'h3 |=> audio_align_strobe)
		else $error("audio strobe did not rise");
	AST_SEC_IGNORE: assert property (reg_wr && reg_addr == 8'h12
		&& reg_wdata[5:4] == 2'h3 && !secondary_align_strobe |=> !secondary_align_strobe)
		else $error("never-align write raised strobe");
	AST_TER_MODE: assert property (reg_wr && reg_addr == 8'h13
		|=> tertiary_frame_align_mode == wdata_q[5:4])
		else $error("tertiary mode not stored");
	AST_SEC_DECODE: assert property (1'b1
		|=> oneshot_align[0] == ($past(secondary_frame_align_mode) == 2'h1))
		else $error("one-shot decode wrong");
	AST_TRIG_READ: assert property (reg_rd |=> reg_rdata[0] == 1'b0
		&& reg_rdata[7:6] == 2'h0)
		else $error("trigger or reserved bit read nonzero");
	AST_AUD_READ: assert property (reg_rd && !reg_wr && reg_addr == 8'h14
		|=> reg_rdata[5:3] == {audio_sync_align_mode, audio_trigger_source_sel})
		else $error("audio register readback wrong");
	AST_PRIMARY: assert property (h_only |=> primary_align_mode_eff == 2'h3)
		else $error("primary mode not forced to never");
endmodule
bind fac_top fac_top_props fac_top_props_i
(
	.mclk(mclk),
	.reset(reset),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.h_only(h_only),
	.primary_align_mode_eff(primary_align_mode_eff),
	.secondary_frame_align_mode(secondary_frame_align_mode),
	.tertiary_frame_align_mode(tertiary_frame_align_mode),
	.audio_sync_align_mode(audio_sync_align_mode),
	.audio_trigger_source_sel(audio_trigger_source_sel),
	.oneshot_align(oneshot_align),
	.secondary_align_strobe(secondary_align_strobe),
	.tertiary_align_strobe(tertiary_align_strobe),
	.audio_align_strobe(audio_align_strobe)
);

/* File: dv/fac_top_tb_top.sv */
// self-checking bench for frame alignment control
`timescale 1ns/1ps
`include "fac_map.vh"
module fac_top_tb_top;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic mclk, reset, reg_wr, reg_rd, init_pin, h_only, hsync_pulse, src;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, a;
	logic [1:0] primary_mode_raw, prim_eff, sec_m, ter_m, aud_m;
	logic [2:0] auto_f, always_f, oneshot_f;
	wire [2:0] st; // strobes: secondary, tertiary, audio
	integer failures, checked, n, w, c, i;
	// ----------------------------------------
	// clock and parts
	// ----------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	fac_video_model fac_video_model_i (.mclk(mclk), .reset(reset), .hsync_pulse(hsync_pulse));
	fac_top fac_top_i (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hsync_pulse(hsync_pulse),
		.lines_per_frame(13'h0003), .init_pin(init_pin), .h_only(h_only),
		.primary_mode_raw(primary_mode_raw), .primary_align_mode_eff(prim_eff),
		.secondary_frame_align_mode(sec_m), .tertiary_frame_align_mode(ter_m),
		.audio_sync_align_mode(aud_m), .audio_trigger_source_sel(src), .auto_align(auto_f),
		.always_align(always_f), .oneshot_align(oneshot_f), .secondary_align_strobe(st[0]),
		.tertiary_align_strobe(st[1]), .audio_align_strobe(st[2]));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one-cycle write strobe
	task wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge mclk); #1;
		reg_addr = ad; reg_wdata = d; reg_wr = 1'b1;
		@(posedge mclk); #1;
		reg_wr = 1'b0;
	endtask
	// one-cycle read strobe, data lands in rd
	task rdr(input logic [7:0] ad);
		@(posedge mclk); #1;
		reg_addr = ad; reg_rd = 1'b1;
		@(posedge mclk); #1;
		reg_rd = 1'b0;
		rd = reg_rdata;
	endtask
	// count cycles and line syncs while a strobe stays high, sampled after each edge
	task width(input integer ch);
		integer k;
		n = 0;
		w = 0;
		for (k = 0; k < 400; k++)
		begin
			if (!st[ch]) break;
			w++;
			if (hsync_pulse) n++;
			@(posedge mclk); #1;
		end
	endtask
	task final_report;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial
	begin
		#100000;
		failures++;
		final_report;
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		failures = 0; checked = 0; reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
		reg_addr = 8'h00; reg_wdata = 8'h00; init_pin = 1'b0; h_only = 1'b0;
		primary_mode_raw = 2'h0;
		repeat (16) @(posedge mclk);
		#1 reset = 1'b0;
		// reset values, then unmapped read
		for (c = 0; c < 3; c++)
		begin
			rdr(`FAC_SECONDARY_CTRL_ADDR + c[7:0]);
			cmp("reset value", 8'h30, rd);
		end
		rdr(8'h15);
		cmp("unmapped read", 8'h00, rd);
		cmp("source select reset", 8'h00, {7'h00, src});
		// every mode code on every channel
		for (c = 0; c < 3; c++)
			for (i = 0; i < 4; i++)
			begin
				a = `FAC_SECONDARY_CTRL_ADDR + c[7:0];
				wr(a, {2'h0, i[1:0], 4'h0});
				rdr(a);
				cmp("mode readback", {2'h0, i[1:0], 4'h0}, rd);
				cmp("mode decode", {5'h00, i == 0, i == 2, i == 1},
					{5'h00, auto_f[c], always_f[c], oneshot_f[c]});
				cmp("mode field", {6'h00, i[1:0]},
					{6'h00, (c == 0) ? sec_m : (c == 1) ? ter_m : aud_m});
			end
		// register triggers: immediate rise, width, self-clear
		for (c = 0; c < 3; c++)
		begin
			a = `FAC_SECONDARY_CTRL_ADDR + c[7:0];
			wr(a, (c == 2) ? 8'h19 : 8'h11);
			cmp("strobe rise", 8'h01, {7'h00, st[c]});
			width(c);
			cmp("strobe lines", 8'h05, n[7:0]);
			cmp("strobe cycles in bounds", 8'h01, {7'h00, w >= 32 && w <= 40});
			rdr(a);
			cmp("trigger reads zero", (c == 2) ? 8'h18 : 8'h10, rd);
			wr(a, (c == 2) ? 8'h39 : 8'h31);
			repeat (3) @(posedge mclk);
			#1 cmp("never mode trigger", 8'h00, {7'h00, st[c]});
		end
		// audio register trigger with pin source selected
		wr(`FAC_AUDIO_CTRL_ADDR, 8'h11);
		cmp("pin source reg trigger", 8'h00, {7'h00, st[2]});
		// pin rising edge through the synchroniser
		init_pin = 1'b1;
		repeat (4) @(posedge mclk);
		#1 cmp("pin strobe", 8'h01, {7'h00, st[2]});
		init_pin = 1'b0;
		width(2);
		cmp("pin strobe lines", 8'h05, n[7:0]);
		cmp("pin strobe cycles in bounds", 8'h01, {7'h00, w >= 32 && w <= 40});
		// pin ignored in never-align mode
		wr(`FAC_AUDIO_CTRL_ADDR, 8'h30);
		init_pin = 1'b1;
		repeat (8) @(posedge mclk);
		#1 cmp("pin in never mode", 8'h00, {7'h00, st[2]});
		init_pin = 1'b0;
		// horizontal-only forces primary to never
		h_only = 1'b1;
		primary_mode_raw = 2'h1;
		repeat (2) @(posedge mclk);
		#1 cmp("primary forced", 8'h03, {6'h00, prim_eff});
		h_only = 1'b0;
		repeat (2) @(posedge mclk);
		#1 cmp("primary free", 8'h01, {6'h00, prim_eff});
		final_report;
	end
endmodule
